// [logic/flash_cmd_decoder.sv]
// instruction decoder and bank address former for a serial nor flash
`timescale 1ns/10ps
module flash_cmd_decoder
(
	input wire logic clock, // 200 MHz core clock
	input wire logic rstn, // asynchronous reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic cs_n, // chip select pin, active low
	input wire logic sck, // serial clock pin from the host
	input wire logic [3:0] io_in, // io pins, bit 0 is the serial input
	output logic so_out, // serial output data
	output logic so_oe, // serial output enable
	output flash_cmd_pkg::cmd_t cmd, // decoded command
	output logic cmd_valid, // one-cycle pulse, cmd is new
	output logic [31:0] addr_out, // full 32-bit start address
	output logic addr_valid, // one-cycle pulse, addr_out is new
	output logic [7:0] data_out, // write data byte
	output logic data_valid, // one-cycle pulse, data_out is new
	output logic [7:0] bank_out // bank selection register contents
);

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic cs_q1, cs_q2; // chip select chain
	logic sck_q1, sck_q2, sck_q3; // clock chain, third stage for edges
	logic [3:0] io_q1, io_q2; // data chain

	// pins are asynchronous to the core clock; only the second stage is read, plus the third for the clock
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			cs_q1 <= 1'b1;
			cs_q2 <= 1'b1;
			sck_q1 <= 1'b0;
			sck_q2 <= 1'b0;
			sck_q3 <= 1'b0;
			io_q1 <= 4'h0;
			io_q2 <= 4'h0;
		end
		else if (ce)
		begin
			cs_q1 <= cs_n;
			cs_q2 <= cs_q1;
			sck_q1 <= sck;
			sck_q2 <= sck_q1;
			sck_q3 <= sck_q2;
			io_q1 <= io_in;
			io_q2 <= io_q1;
		end
	end

	// ****************************************************************
	// state
	// ****************************************************************
	flash_cmd_pkg::phase_t phase_reg; // current phase of the command
	logic [5:0] cnt_reg; // bits taken in this phase
	logic [31:0] sh_reg; // input shift register
	logic [7:0] bank_reg; // bank selection register
	logic [7:0] out_sh_reg; // output shift register
	flash_cmd_pkg::cmd_t cmd_reg; // latched decode
	logic rise, fall, take; // serial clock events
	logic [2:0] width_now; // bits per edge in this phase
	logic [31:0] sh_next; // shift register after this edge
	logic [5:0] cnt_next; // bit count after this edge
	logic [5:0] addr_need; // address length in bits
	logic long_mode; // four bytes expected for this command
	flash_cmd_pkg::cmd_t dec; // decode of the byte just completed

	// edges count only while selected; the host idles the clock otherwise
	assign rise = sck_q2 & ~sck_q3 & ~cs_q2;
	assign fall = ~sck_q2 & sck_q3 & ~cs_q2;
	// double-rate headers are taken on both edges, but the fall right after the
	// instruction carries nothing: the address starts on the next rise
	assign take = rise | (fall & cmd_reg.ddr & (phase_reg == flash_cmd_pkg::st_addr) &
		(cnt_reg != 6'h00));

	// ****************************************************************
	// decode
	// ****************************************************************
	function automatic flash_cmd_pkg::cmd_t decode(input logic [7:0] op);
		flash_cmd_pkg::cmd_t c;
		c = '0;
		c.cls = flash_cmd_pkg::cls_none;
		c.opcode = op;
		c.addr_mode = flash_cmd_pkg::addr_none;
		c.addr_width = 3'h1;
		c.data_width = 3'h1;
		c.max_mhz = 8'h85;
		unique case (op)
			flash_cmd_pkg::op_maker_signature_read,
			flash_cmd_pkg::op_parameter_table_read:
				c.cls = flash_cmd_pkg::cls_ident;
			flash_cmd_pkg::op_electronic_signature_read:
			begin
				c.cls = flash_cmd_pkg::cls_ident;
				c.max_mhz = 8'h32;
			end
			flash_cmd_pkg::op_identification_read:
				c.cls = flash_cmd_pkg::cls_ident;
			flash_cmd_pkg::op_status_config_write:
			begin
				c.cls = flash_cmd_pkg::cls_reg_write;
				c.has_wdata = 1'b1;
			end
			flash_cmd_pkg::op_status_clear:
				c.cls = flash_cmd_pkg::cls_status_clear;
			flash_cmd_pkg::op_bank_select_read:
				c.cls = flash_cmd_pkg::cls_bank_read;
			flash_cmd_pkg::op_bank_select_write,
			flash_cmd_pkg::op_bank_select_legacy_access:
			begin
				c.cls = flash_cmd_pkg::cls_bank_write;
				c.has_wdata = 1'b1;
			end
			flash_cmd_pkg::op_learning_pattern_read:
				c.cls = flash_cmd_pkg::cls_learn_read;
			flash_cmd_pkg::op_nonvolatile_learning_program,
			flash_cmd_pkg::op_volatile_learning_write:
			begin
				c.cls = flash_cmd_pkg::cls_learn_write;
				c.has_wdata = 1'b1;
			end
			flash_cmd_pkg::op_correction_status_read:
			begin
				c.cls = flash_cmd_pkg::cls_ecc_read;
				c.addr_mode = flash_cmd_pkg::addr_four;
			end
			default:
			begin
				// array reads and programs, sorted by family below
			end
		endcase
		// array reads and quad programs: legacy form first, long form second
		unique case (op)
			flash_cmd_pkg::op_normal_read, flash_cmd_pkg::op_normal_read_long_addr:
				c.max_mhz = 8'h32;
			flash_cmd_pkg::op_double_rate_quick_read,
			flash_cmd_pkg::op_double_rate_quick_read_long:
			begin
				c.ddr = 1'b1;
				c.max_mhz = 8'h50;
			end
			flash_cmd_pkg::op_two_bit_output_read, flash_cmd_pkg::op_two_bit_output_read_long,
			flash_cmd_pkg::op_four_bit_output_read,
			flash_cmd_pkg::op_four_bit_output_read_long:
				c.max_mhz = 8'h68;
			flash_cmd_pkg::op_two_bit_io_read, flash_cmd_pkg::op_two_bit_io_read_long:
			begin
				c.addr_width = 3'h2;
				c.max_mhz = 8'h68;
			end
			flash_cmd_pkg::op_double_rate_two_bit_io_read,
			flash_cmd_pkg::op_double_rate_two_bit_io_read_long:
			begin
				c.addr_width = 3'h2;
				c.ddr = 1'b1;
				c.max_mhz = 8'h50;
			end
			flash_cmd_pkg::op_four_bit_io_read, flash_cmd_pkg::op_four_bit_io_read_long:
			begin
				c.addr_width = 3'h4;
				c.max_mhz = 8'h68;
			end
			flash_cmd_pkg::op_double_rate_four_bit_io_read,
			flash_cmd_pkg::op_double_rate_four_bit_io_read_long:
			begin
				c.addr_width = 3'h4;
				c.ddr = 1'b1;
				c.max_mhz = 8'h50;
			end
			flash_cmd_pkg::op_four_bit_page_program,
			flash_cmd_pkg::op_four_bit_page_program_alt,
			flash_cmd_pkg::op_four_bit_page_program_long:
			begin
				c.data_width = 3'h4;
				c.max_mhz = 8'h50;
			end
			default:
			begin
				// 0b/0c quick read and 02/12 program keep single width, 133 MHz
			end
		endcase
		// family and address form
		unique case (op)
			flash_cmd_pkg::op_normal_read, flash_cmd_pkg::op_quick_read,
			flash_cmd_pkg::op_double_rate_quick_read, flash_cmd_pkg::op_two_bit_output_read,
			flash_cmd_pkg::op_four_bit_output_read, flash_cmd_pkg::op_two_bit_io_read,
			flash_cmd_pkg::op_double_rate_two_bit_io_read, flash_cmd_pkg::op_four_bit_io_read,
			flash_cmd_pkg::op_double_rate_four_bit_io_read:
			begin
				c.cls = flash_cmd_pkg::cls_array_read;
				c.addr_mode = flash_cmd_pkg::addr_legacy;
			end
			flash_cmd_pkg::op_normal_read_long_addr, flash_cmd_pkg::op_quick_read_long_addr,
			flash_cmd_pkg::op_double_rate_quick_read_long,
			flash_cmd_pkg::op_two_bit_output_read_long,
			flash_cmd_pkg::op_four_bit_output_read_long,
			flash_cmd_pkg::op_two_bit_io_read_long,
			flash_cmd_pkg::op_double_rate_two_bit_io_read_long,
			flash_cmd_pkg::op_four_bit_io_read_long,
			flash_cmd_pkg::op_double_rate_four_bit_io_read_long:
			begin
				c.cls = flash_cmd_pkg::cls_array_read;
				c.addr_mode = flash_cmd_pkg::addr_four;
			end
			flash_cmd_pkg::op_page_program, flash_cmd_pkg::op_four_bit_page_program,
			flash_cmd_pkg::op_four_bit_page_program_alt:
			begin
				c.cls = flash_cmd_pkg::cls_program;
				c.addr_mode = flash_cmd_pkg::addr_legacy;
				c.has_wdata = 1'b1;
			end
			flash_cmd_pkg::op_page_program_long_addr,
			flash_cmd_pkg::op_four_bit_page_program_long:
			begin
				c.cls = flash_cmd_pkg::cls_program;
				c.addr_mode = flash_cmd_pkg::addr_four;
				c.has_wdata = 1'b1;
			end
			default:
			begin
				// non-array commands were classed above
			end
		endcase
		return c;
	endfunction

	// ****************************************************************
	// shift datapath
	// ****************************************************************
	// width for this phase, then the shifted word and count
	always_comb
	begin
		unique case (phase_reg)
			flash_cmd_pkg::st_addr: width_now = cmd_reg.addr_width;
			flash_cmd_pkg::st_data: width_now = cmd_reg.data_width;
			default: width_now = 3'h1;
		endcase
		unique case (width_now)
			3'h2: sh_next = {sh_reg[29:0], io_q2[1:0]};
			3'h4: sh_next = {sh_reg[27:0], io_q2};
			default: sh_next = {sh_reg[30:0], io_q2[0]};
		endcase
		cnt_next = cnt_reg + 6'(width_now);
	end

	assign dec = decode(sh_next[7:0]);
	// the long enable only reshapes legacy commands
	assign long_mode = (cmd_reg.addr_mode == flash_cmd_pkg::addr_four) |
		bank_reg[flash_cmd_pkg::bank_long_enable_bit];
	assign addr_need = long_mode ? flash_cmd_pkg::long_addr_bits :
		flash_cmd_pkg::short_addr_bits;

	// ****************************************************************
	// phase sequencer
	// ****************************************************************
	// chip select high always ends the command and rearms the decoder
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			phase_reg <= flash_cmd_pkg::st_instr;
			cnt_reg <= 6'h00;
			sh_reg <= 32'h0000_0000;
			cmd_reg <= '0;
		end
		else if (ce)
		begin
			if (cs_q2)
			begin
				phase_reg <= flash_cmd_pkg::st_instr;
				cnt_reg <= 6'h00;
			end
			else if (take)
			begin
				sh_reg <= sh_next;
				cnt_reg <= cnt_next;
				unique case (phase_reg)
					flash_cmd_pkg::st_instr:
						if (cnt_next == flash_cmd_pkg::instr_bits)
						begin
							cmd_reg <= dec;
							cnt_reg <= 6'h00;
							if (dec.cls == flash_cmd_pkg::cls_none)
								phase_reg <= flash_cmd_pkg::st_skip;
							else if (dec.addr_mode != flash_cmd_pkg::addr_none)
								phase_reg <= flash_cmd_pkg::st_addr;
							else if (dec.has_wdata)
								phase_reg <= flash_cmd_pkg::st_data;
							else if (dec.cls == flash_cmd_pkg::cls_bank_read)
								phase_reg <= flash_cmd_pkg::st_out;
							else
								phase_reg <= flash_cmd_pkg::st_skip;
						end
					flash_cmd_pkg::st_addr:
						if (cnt_next == addr_need)
						begin
							cnt_reg <= 6'h00;
							// read data, latency and the rest lie beyond this block
							phase_reg <= cmd_reg.has_wdata ? flash_cmd_pkg::st_data :
								flash_cmd_pkg::st_skip;
						end
					flash_cmd_pkg::st_data:
						if (cnt_next == flash_cmd_pkg::data_byte_bits)
							cnt_reg <= 6'h00;
					flash_cmd_pkg::st_out:
						cnt_reg <= 6'h01; // first read rise arms the output shifter
					flash_cmd_pkg::st_skip:
						cnt_reg <= 6'h00;
				endcase
			end
		end
	end

	// ****************************************************************
	// result strobes
	// ****************************************************************
	// one pulse per finished field; data stays until the next field
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			cmd_valid <= 1'b0;
			addr_valid <= 1'b0;
			data_valid <= 1'b0;
			addr_out <= 32'h0000_0000;
			data_out <= 8'h00;
		end
		else if (ce)
		begin
			cmd_valid <= 1'b0;
			addr_valid <= 1'b0;
			data_valid <= 1'b0;
			if (!cs_q2 && take)
			begin
				if (phase_reg == flash_cmd_pkg::st_instr && cnt_next == flash_cmd_pkg::instr_bits)
					cmd_valid <= 1'b1;
				if (phase_reg == flash_cmd_pkg::st_addr && cnt_next == addr_need)
				begin
					addr_valid <= 1'b1;
					// short form: bank register supplies the top byte, read once here
					if (long_mode)
						addr_out <= sh_next;
					else
						addr_out <= {6'h00, bank_reg[1:0], sh_next[23:0]};
				end
				if (phase_reg == flash_cmd_pkg::st_data &&
					cnt_next == flash_cmd_pkg::data_byte_bits)
				begin
					data_valid <= 1'b1;
					data_out <= sh_next[7:0];
				end
			end
		end
	end

	// ****************************************************************
	// bank selection register
	// ****************************************************************
	// volatile: reset gives bank 0 and three-byte addressing; reads never touch it
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			bank_reg <= flash_cmd_pkg::bank_reset_value;
		else if (ce && !cs_q2 && take && phase_reg == flash_cmd_pkg::st_data &&
			cmd_reg.cls == flash_cmd_pkg::cls_bank_write &&
			cnt_next == flash_cmd_pkg::data_byte_bits)
			bank_reg <= sh_next[7:0] & flash_cmd_pkg::bank_write_mask;
	end

	// ****************************************************************
	// bank read output
	// ****************************************************************
	// loaded with the instruction; the first fall only launches bit 7, so shifting
	// waits for a read rise, else the host would take bit 6 first; repeats the byte
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			out_sh_reg <= 8'h00;
		else if (ce)
		begin
			if (phase_reg == flash_cmd_pkg::st_instr)
				out_sh_reg <= bank_reg;
			else if (phase_reg == flash_cmd_pkg::st_out && fall && cnt_reg != 6'h00)
				out_sh_reg <= {out_sh_reg[6:0], out_sh_reg[7]};
		end
	end

	assign so_out = out_sh_reg[7];
	assign so_oe = (phase_reg == flash_cmd_pkg::st_out) & ~cs_q2;
	assign cmd = cmd_reg;
	assign bank_out = bank_reg;

	// ****************************************************************
	// assertions
	// ****************************************************************
	sequence s_decoded(logic [7:0] op);
		cmd_valid && cmd.opcode == op;
	endsequence

	sequence s_short_addr;
		addr_valid && !bank_reg[7] && cmd.addr_mode == flash_cmd_pkg::addr_legacy;
	endsequence

	property p_bank_map;
		@(posedge clock) disable iff (!rstn)
		s_short_addr |-> addr_out[31:24] == {6'h00, bank_reg[1:0]};
	endproperty
	a_bank_map: assert property (p_bank_map) else $error("bank byte wrong");

	property p_sig_decode;
		@(posedge clock) disable iff (!rstn)
		(s_decoded(8'h90) or s_decoded(8'hab) or s_decoded(8'h5a))
			|-> cmd.cls == flash_cmd_pkg::cls_ident;
	endproperty
	a_sig_decode: assert property (p_sig_decode) else $error("signature misdecoded");

	property p_id_decode;
		@(posedge clock) disable iff (!rstn)
		s_decoded(8'h9f) |-> cmd.cls == flash_cmd_pkg::cls_ident ##1
			phase_reg == flash_cmd_pkg::st_skip;
	endproperty
	a_id_decode: assert property (p_id_decode) else $error("id misdecoded");

	property p_wr_decode;
		@(posedge clock) disable iff (!rstn)
		s_decoded(8'h01) |-> cmd.cls == flash_cmd_pkg::cls_reg_write && cmd.has_wdata;
	endproperty
	a_wr_decode: assert property (p_wr_decode) else $error("status write misdecoded");

	property p_bank_write;
		@(posedge clock) disable iff (!rstn)
		data_valid && cmd.cls == flash_cmd_pkg::cls_bank_write
			|-> bank_reg == (data_out & flash_cmd_pkg::bank_write_mask);
	endproperty
	a_bank_write: assert property (p_bank_write) else $error("bank not written");

	property p_ecc_long;
		@(posedge clock) disable iff (!rstn)
		s_decoded(8'h18) |-> cmd.addr_mode == flash_cmd_pkg::addr_four;
	endproperty
	a_ecc_long: assert property (p_ecc_long) else $error("ecc read not long");

	property p_quad_io;
		@(posedge clock) disable iff (!rstn)
		(s_decoded(8'heb) or s_decoded(8'hec)) |-> cmd.addr_width == 3'h4 && !cmd.ddr;
	endproperty
	a_quad_io: assert property (p_quad_io) else $error("quad io misdecoded");

	property p_reset_bank;
		@(posedge clock) disable iff (!rstn)
		$rose(rstn) |-> bank_reg == flash_cmd_pkg::bank_reset_value;
	endproperty
	a_reset_bank: assert property (p_reset_bank) else $error("bank not cleared");

	property p_skip_unknown;
		@(posedge clock) disable iff (!rstn)
		cmd_valid && cmd.cls == flash_cmd_pkg::cls_none
			|=> (!addr_valid && !data_valid && !so_oe)[*4];
	endproperty
	a_skip_unknown: assert property (p_skip_unknown) else $error("unknown acted");

endmodule

// [logic/flash_cmd_pkg.sv]
// constants and types shared by the serial flash instruction decoder
package flash_cmd_pkg;

	// ****************************************************************
	// instruction codes
	// ****************************************************************
	localparam logic [7:0] op_maker_signature_read = 8'h90;
	localparam logic [7:0] op_identification_read = 8'h9f;
	localparam logic [7:0] op_electronic_signature_read = 8'hab;
	localparam logic [7:0] op_parameter_table_read = 8'h5a;
	localparam logic [7:0] op_status_config_write = 8'h01;
	localparam logic [7:0] op_status_clear = 8'h30;
	localparam logic [7:0] op_correction_status_read = 8'h18;
	localparam logic [7:0] op_bank_select_read = 8'h16;
	localparam logic [7:0] op_bank_select_write = 8'h17;
	localparam logic [7:0] op_bank_select_legacy_access = 8'hb9;
	localparam logic [7:0] op_learning_pattern_read = 8'h41;
	localparam logic [7:0] op_nonvolatile_learning_program = 8'h43;
	localparam logic [7:0] op_volatile_learning_write = 8'h4a;
	localparam logic [7:0] op_normal_read = 8'h03;
	localparam logic [7:0] op_normal_read_long_addr = 8'h13;
	localparam logic [7:0] op_quick_read = 8'h0b;
	localparam logic [7:0] op_quick_read_long_addr = 8'h0c;
	localparam logic [7:0] op_double_rate_quick_read = 8'h0d;
	localparam logic [7:0] op_double_rate_quick_read_long = 8'h0e;
	localparam logic [7:0] op_two_bit_output_read = 8'h3b;
	localparam logic [7:0] op_two_bit_output_read_long = 8'h3c;
	localparam logic [7:0] op_four_bit_output_read = 8'h6b;
	localparam logic [7:0] op_four_bit_output_read_long = 8'h6c;
	localparam logic [7:0] op_two_bit_io_read = 8'hbb;
	localparam logic [7:0] op_two_bit_io_read_long = 8'hbc;
	localparam logic [7:0] op_double_rate_two_bit_io_read = 8'hbd;
	localparam logic [7:0] op_double_rate_two_bit_io_read_long = 8'hbe;
	localparam logic [7:0] op_four_bit_io_read = 8'heb;
	localparam logic [7:0] op_four_bit_io_read_long = 8'hec;
	localparam logic [7:0] op_double_rate_four_bit_io_read = 8'hed;
	localparam logic [7:0] op_double_rate_four_bit_io_read_long = 8'hee;
	localparam logic [7:0] op_page_program = 8'h02;
	localparam logic [7:0] op_page_program_long_addr = 8'h12;
	localparam logic [7:0] op_four_bit_page_program = 8'h32;
	localparam logic [7:0] op_four_bit_page_program_alt = 8'h38;
	localparam logic [7:0] op_four_bit_page_program_long = 8'h34;

	// ****************************************************************
	// bank selection register layout and reset value
	// ****************************************************************
	localparam int bank_long_enable_bit = 7; // long address enable position
	localparam int bank_sel_lsb = 0; // bank field low bit
	localparam int bank_sel_width = 2; // four banks
	localparam logic [7:0] bank_reset_value = 8'h00; // bank 0, three-byte mode
	localparam logic [7:0] bank_write_mask = 8'h83; // writable bits

	// ****************************************************************
	// phase lengths in bits
	// ****************************************************************
	localparam logic [5:0] instr_bits = 6'h08; // one instruction byte
	localparam logic [5:0] short_addr_bits = 6'h18; // three address bytes
	localparam logic [5:0] long_addr_bits = 6'h20; // four address bytes
	localparam logic [5:0] data_byte_bits = 6'h08; // one data byte

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [3:0] {
		cls_none, cls_ident, cls_reg_write, cls_status_clear, cls_bank_read,
		cls_bank_write, cls_learn_read, cls_learn_write, cls_ecc_read,
		cls_array_read, cls_program
	} cmd_class_t;

	typedef enum logic [1:0] {
		addr_none, addr_legacy, addr_four
	} addr_mode_t;

	typedef struct packed {
		cmd_class_t cls; // command family
		logic [7:0] opcode; // raw instruction byte
		addr_mode_t addr_mode; // address field form
		logic [2:0] addr_width; // bits per clock edge in address
		logic [2:0] data_width; // bits per clock edge in write data
		logic ddr; // address taken on both edges
		logic has_wdata; // host sends data bytes after the header
		logic [7:0] max_mhz; // highest host clock allowed
	} cmd_t;

	typedef enum logic [2:0] {
		st_instr, st_addr, st_data, st_out, st_skip
	} phase_t;

endpackage

// [verification/spi_host_model.sv]
// host serial controller model that drives the flash link
`timescale 1ns/10ps
module spi_host_model
(
	output logic cs_n, // chip select, active low
	output logic sck, // serial clock, idles low
	output logic [3:0] io // io lines into the device
);
	// ****
	// idle lines
	// ****
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
		io = 4'h5;
	end
	// msb first; 48 ns period stays under every clock limit
	task automatic shift(input logic [31:0] val, input int nbits);
		for (int i = nbits - 1; i >= 0; i--)
		begin
			io = {~io[3:1], val[i]};
			#24 sck = 1'b1;
			#24 sck = 1'b0;
		end
	endtask
	// w bits per edge, msb group first; double rate moves on every edge,
	// with each half period kept at 24 ns like the single rate clock
	task automatic shift_w(input logic [31:0] val, input int nbits, input int w, input bit ddr);
		for (int i = nbits / w - 1; i >= 0; i--)
		begin
			if (ddr)
			begin
				#12 io = 4'((val >> (i * w)) & ((32'h1 << w) - 32'h1));
				#12 sck = ~sck;
			end
			else
			begin
				io = 4'((val >> (i * w)) & ((32'h1 << w) - 32'h1));
				#24 sck = 1'b1;
				#24 sck = 1'b0;
			end
		end
	endtask
	// select with margin for the pin synchronisers
	task automatic start();
		#30 cs_n = 1'b0;
		#30;
	endtask
	// released lines flip so no stale bit looks valid
	task automatic stop();
		#30 cs_n = 1'b1;
		io = ~io;
		#60;
	endtask
endmodule

// [verification/flash_cmd_decoder_tb_top.sv]
// self-checking bench for the flash instruction decoder
`timescale 1ns/10ps
module flash_cmd_decoder_tb_top;
	logic clock = 1'b0; // 200 MHz core clock
	logic rstn = 1'b0; // reset, active low
	logic ce = 1'b1; // kept running; freezing is not exercised
	logic cs_n, sck, so_out, so_oe, cmd_valid, addr_valid, data_valid, saw_oe;
	logic [3:0] io;
	logic [31:0] addr_out, got_addr, a;
	logic [7:0] data_out, bank_out, got_dat, b, got_so;
	flash_cmd_pkg::cmd_t cmd, got_cmd;
	int failures = 0, checks_done = 0, n_cmd, n_adr, n_dat, seed = 32'h670b49de;
	logic [7:0] ops [36] = '{8'h90, 8'h9f, 8'hab, 8'h5a, 8'h01, 8'h30, 8'h18, 8'h16, 8'h17,
		8'hb9, 8'h41, 8'h43, 8'h4a, 8'h03, 8'h13, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h3b, 8'h3c,
		8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'heb, 8'hec, 8'hed, 8'hee, 8'h02, 8'h12,
		8'h32, 8'h38, 8'h34};
	always #2.5 clock = ~clock;
	spi_host_model u_host (.cs_n(cs_n), .sck(sck), .io(io));
	flash_cmd_decoder u_dut (.clock(clock), .rstn(rstn), .ce(ce), .cs_n(cs_n), .sck(sck),
		.io_in(io), .so_out(so_out), .so_oe(so_oe), .cmd(cmd), .cmd_valid(cmd_valid),
		.addr_out(addr_out), .addr_valid(addr_valid), .data_out(data_out),
		.data_valid(data_valid), .bank_out(bank_out));
	// ****
	// pulse monitor: counts and latches each one-cycle pulse
	// ****
	always @(posedge clock)
	begin
		n_cmd += (cmd_valid === 1'b1);
		n_adr += (addr_valid === 1'b1);
		n_dat += (data_valid === 1'b1);
		saw_oe |= (so_oe === 1'b1);
		if (cmd_valid === 1'b1)
			got_cmd = cmd;
		if (addr_valid === 1'b1)
			got_addr = addr_out;
		if (data_valid === 1'b1)
			got_dat = data_out;
	end
	// bank read bits as the host takes them, on its own rising edge
	always @(posedge sck)
		if (so_oe === 1'b1)
			got_so = {got_so[6:0], so_out};
	// address field shape as the host sends it
	function automatic int adr_w(input logic [7:0] op);
		case (op)
			8'hbb, 8'hbc, 8'hbd, 8'hbe: adr_w = 2;
			8'heb, 8'hec, 8'hed, 8'hee: adr_w = 4;
			default: adr_w = 1;
		endcase
	endfunction
	function automatic bit dbl(input logic [7:0] op);
		case (op)
			8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee: dbl = 1'b1;
			default: dbl = 1'b0;
		endcase
	endfunction
	// expected family of an instruction byte
	function automatic flash_cmd_pkg::cmd_class_t exp_cls(input logic [7:0] op);
		case (op)
			8'h90, 8'h9f, 8'hab, 8'h5a: exp_cls = flash_cmd_pkg::cls_ident;
			8'h01: exp_cls = flash_cmd_pkg::cls_reg_write;
			8'h30: exp_cls = flash_cmd_pkg::cls_status_clear;
			8'h16: exp_cls = flash_cmd_pkg::cls_bank_read;
			8'h17, 8'hb9: exp_cls = flash_cmd_pkg::cls_bank_write;
			8'h41: exp_cls = flash_cmd_pkg::cls_learn_read;
			8'h43, 8'h4a: exp_cls = flash_cmd_pkg::cls_learn_write;
			8'h18: exp_cls = flash_cmd_pkg::cls_ecc_read;
			8'h03, 8'h13, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h3b, 8'h3c, 8'h6b, 8'h6c, 8'hbb, 8'hbc,
			8'hbd, 8'hbe, 8'heb, 8'hec, 8'hed, 8'hee: exp_cls = flash_cmd_pkg::cls_array_read;
			8'h02, 8'h12, 8'h32, 8'h38, 8'h34: exp_cls = flash_cmd_pkg::cls_program;
			default: exp_cls = flash_cmd_pkg::cls_none;
		endcase
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want)
		begin
			failures++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic close_out();
		if (failures == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// one framed command: opcode, then tb bits of tail
	task automatic frame(input logic [7:0] op, input logic [31:0] tail, input int tb);
		n_cmd = 0;
		n_adr = 0;
		n_dat = 0;
		saw_oe = 1'b0;
		u_host.start();
		u_host.shift({24'h0, op}, 8);
		if (tb > 0 && (adr_w(op) > 1 || dbl(op)))
			u_host.shift_w(tail, tb, adr_w(op), dbl(op));
		else if (tb > 0)
			u_host.shift(tail, tb);
		u_host.stop();
		check(n_cmd, 1);
		check(got_cmd.cls, exp_cls(op));
		check(got_cmd.opcode, op);
	endtask
	// ****
	// main sequence
	// ****
	initial
	begin
		repeat (5) @(negedge clock);
		rstn = 1'b1;
		repeat (6) @(negedge clock);
		check(bank_out, 8'h00);
		foreach (ops[i])
		begin
			frame(ops[i], 32'h0, 0);
			if (ops[i] == 8'h16)
				check(saw_oe, 1'b1);
		end
		// random opcodes with trailing bytes; unknown ones must stay silent
		repeat (12)
		begin
			b = $random(seed);
			frame(b, $random(seed), 32);
			if (exp_cls(b) == flash_cmd_pkg::cls_none)
				check(n_adr + n_dat, 0);
		end
		for (int k = 0; k < 4; k++)
		begin
			b = {1'b0, 5'($random(seed)), 2'(k)};
			a = $random(seed);
			frame(8'h17, b, 8);
			check(got_dat, b);
			check(bank_out, b & flash_cmd_pkg::bank_write_mask);
			frame(8'h03, a, 24);
			check(got_addr, {6'h0, 2'(k), a[23:0]});
			frame(8'hed, a, 24);
			check(got_addr, {6'h0, 2'(k), a[23:0]});
			frame(8'hbc, ~a, 32);
			check(got_addr, ~a);
			frame(8'h0d, a, 24);
			check(got_addr, {6'h0, 2'(k), a[23:0]});
			frame(8'h13, a, 32);
			check(got_addr, a);
			frame(8'hb9, b | 8'h80, 8);
			frame(8'h16, 32'h0, 8);
			check(got_so, (b | 8'h80) & flash_cmd_pkg::bank_write_mask);
			frame(8'h0b, a, 32);
			check(got_addr, a);
			frame(8'h18, ~a, 32);
			check(got_addr, ~a);
		end
		close_out();
	end
	// watchdog well beyond the expected run length
	initial
	begin
		#300000;
		failures++;
		close_out();
	end
endmodule
